// file: src/lrd_line_receiver.sv
// lrd_line_receiver: lock control, line decoder and LOS detection
// assumes: line clock and data come from clock recovery, all pins but the register port
// asynchronous; freq_off_i and amp_low_i are on ref_clk_i already
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lrd_line_receiver (
  input wire logic ref_clk_i,             // 20 MHz system clock
  input wire logic rst_i,                 // async reset, active high
  input wire logic reference_clock_in_i,  // external reference clock
  input wire logic line_clock_i,          // recovered line clock
  input wire logic line_in_pos_i,         // retimed positive pulse
  input wire logic line_in_neg_i,         // retimed negative pulse
  input wire logic freq_off_i,            // clocks differ over 0.5%
  input wire logic amp_low_i,             // amplitude under threshold
  input wire logic host_mode_i,           // 1: bits rule, 0: pins rule
  input wire logic rail_format_select_i,  // hw: 1 single rail
  input wire logic rx_equalizer_enable_i, // hw: equalizer in
  input wire logic rx_monitor_gain_enable_i, // monitor gain pin
  input wire logic loss_data_mute_i,      // hw: mute data on LOS
  input wire logic [3:0] addr_i,          // register address
  input wire logic [31:0] wdata_i,        // write data
  input wire logic wr_i,                  // write strobe
  input wire logic rd_i,                  // read strobe
  output logic [31:0] rdata_o,            // read data, next cycle
  output logic rx_clock_out_o,            // receive clock out
  output logic rx_data_pos_o,             // data / positive rail
  output logic rx_data_neg_o,             // negative rail
  output logic line_code_violation_o,     // one-cycle violation pulse
  output logic rx_loss_of_lock_o,         // training state
  output logic combined_signal_loss_o,    // combined LOS
  output logic rx_equalizer_enable_o,     // equalizer switched in
  output logic rx_monitor_gain_enable_o   // 20 dB stage on
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  lrd_pkg::lrd_pins_t pin_raw, pin_s1, pin_s2, pin_s3;

  assign pin_raw = '{host: host_mode_i, rail: rail_format_select_i,
                     eq: rx_equalizer_enable_i,
                     mon: rx_monitor_gain_enable_i,
                     mute: loss_data_mute_i, lclk: line_clock_i,
                     rclk: reference_clock_in_i, pos: line_in_pos_i,
                     neg: line_in_neg_i};

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= lrd_pkg::PINS_RST;
      pin_s2 <= lrd_pkg::PINS_RST;
      pin_s3 <= lrd_pkg::PINS_RST;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lrd_pkg::lrd_ctrl_t ctrl_q, ctrl_d;
  lrd_pkg::lrd_stat_t stat;
  logic [31:0] rdata_q, rdata_d;

  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = 32'h0000_0000;
    if (wr_i && addr_i == lrd_pkg::ADDR_CTRL)
      ctrl_d = wdata_i[$bits(lrd_pkg::lrd_ctrl_t)-1:0];
    if (rd_i)
    begin
      unique case (addr_i)
        lrd_pkg::ADDR_CTRL:
          rdata_d[$bits(lrd_pkg::lrd_ctrl_t)-1:0] = ctrl_q;
        lrd_pkg::ADDR_STAT:
          rdata_d[$bits(lrd_pkg::lrd_stat_t)-1:0] = stat;
        default:
          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= lrd_pkg::CTRL_RST;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // effective controls, pin or bit by mode; monitor gain is pin OR bit, E3 bit only
  // ----------------------------------------------------------------
  logic single_rail, mute_en, e3;

  assign single_rail = pin_s2.host ? ctrl_q.single_rail
                                   : pin_s2.rail;
  assign mute_en = pin_s2.host ? ctrl_q.los_mute : pin_s2.mute;
  assign e3 = ctrl_q.e3_mode;
  assign rx_equalizer_enable_o = pin_s2.host ? ctrl_q.eq_en
                                             : pin_s2.eq;
  assign rx_monitor_gain_enable_o = ctrl_q.mon_gain | pin_s2.mon;

  // ----------------------------------------------------------------
  // lock state and bit strobe
  // ----------------------------------------------------------------
  lrd_pkg::lrd_cdr_t st_q, st_d;
  logic train_st, clk_now, clk_prev, bit_en, los;
  logic digital_signal_loss_q, digital_signal_loss_d, analog_signal_loss_q, analog_signal_loss_d;
  logic clk_out_q, clk_out_d;

  assign train_st = (st_q == lrd_pkg::CDR_TRAIN);
  // bits follow whichever clock goes out, so zero runs still count
  // while the line clock is gone
  assign clk_now = train_st ? pin_s2.rclk : pin_s2.lclk;
  assign clk_prev = train_st ? pin_s3.rclk : pin_s3.lclk;
  assign bit_en = clk_now & ~clk_prev;
  assign los = digital_signal_loss_q | analog_signal_loss_q;

  always_comb
  begin
    st_d = (los || freq_off_i) ? lrd_pkg::CDR_TRAIN
                               : lrd_pkg::CDR_RECOVER;
    unique case (st_q)
      lrd_pkg::CDR_TRAIN: clk_out_d = pin_s2.rclk;
      lrd_pkg::CDR_RECOVER: clk_out_d = pin_s2.lclk;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= lrd_pkg::CDR_TRAIN;
      clk_out_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      clk_out_q <= clk_out_d;
    end
  end

  assign rx_clock_out_o = clk_out_q;
  assign rx_loss_of_lock_o = train_st;
  assign combined_signal_loss_o = los;
  assign stat = '{los: los, analog_signal_loss: analog_signal_loss_q, digital_signal_loss: digital_signal_loss_q, lol: train_st};

  // ----------------------------------------------------------------
  // decoder, violation check and LOS counters
  // ----------------------------------------------------------------
  logic pulse, pol, viol, sub_ok;
  logic last_pol_q, last_pol_d, have_p_q, have_p_d;
  logic vpol_q, vpol_d, have_v_q, have_v_d;
  logic [3:0] sr_q, sr_d;
  logic [7:0] zrun_q, zrun_d, arun_q, arun_d;
  logic [7:0] win_q, win_d, ones_q, ones_d;
  logic [7:0] run_len, subz;
  logic pos_q, pos_d, neg_q, neg_d, lcv_q, lcv_d;

  assign pulse = pin_s2.pos | pin_s2.neg;
  assign pol = pin_s2.pos;
  assign run_len = e3 ? lrd_pkg::HDB3_RUN : lrd_pkg::B3ZS_RUN;
  assign subz = e3 ? lrd_pkg::HDB3_SUBZ : lrd_pkg::B3ZS_SUBZ;
  assign viol = pulse && have_p_q && (pol == last_pol_q);
  // a substitution V follows enough zeros and alternates with last V
  assign sub_ok = viol && (zrun_q >= subz)
                  && (!have_v_q || pol != vpol_q);

  always_comb
  begin
    {last_pol_d, have_p_d} = {last_pol_q, have_p_q};
    {vpol_d, have_v_d} = {vpol_q, have_v_q};
    {sr_d, zrun_d, arun_d} = {sr_q, zrun_q, arun_q};
    {win_d, ones_d} = {win_q, ones_q};
    {digital_signal_loss_d, analog_signal_loss_d, pos_d, neg_d} = {digital_signal_loss_q, analog_signal_loss_q, pos_q, neg_q};
    lcv_d = 1'b0;
    if (bit_en)
    begin
      if (pulse)
        {last_pol_d, have_p_d} = {pol, 1'b1};
      if (viol)
        {vpol_d, have_v_d} = {pol, 1'b1};
      zrun_d = pulse ? 8'h00 : (zrun_q == lrd_pkg::CNT_MAX)
               ? zrun_q : zrun_q + 8'h01;
      sr_d = {sr_q[2:0], pulse};
      if (sub_ok)
        sr_d = e3 ? 4'h0 : {sr_d[3], 3'h0};
      if (!single_rail)
        lcv_d = (viol && !sub_ok) || (zrun_d == run_len);
      if (single_rail)
        {pos_d, neg_d} = {pin_s2.pos, pin_s2.neg};
      else
        {pos_d, neg_d} = {e3 ? sr_d[3] : sr_d[2], 1'b0};
      if (mute_en && los)
        {pos_d, neg_d} = 2'h0;
      // digital loss, DS3/STS-1 only
      if (!digital_signal_loss_q && !e3 && zrun_d == lrd_pkg::LOS_RUN_C)
        digital_signal_loss_d = 1'b1;
      if (digital_signal_loss_q)
      begin
        win_d = win_q + 8'h01;
        ones_d = ones_q + {7'h00, pulse};
        if (win_d == lrd_pkg::LOS_RUN_C)
        begin
          digital_signal_loss_d = (ones_d < lrd_pkg::CLR_ONES);
          {win_d, ones_d} = 16'h0000;
        end
      end
      else
        {win_d, ones_d} = 16'h0000;
      arun_d = !amp_low_i ? 8'h00 : (arun_q == lrd_pkg::CNT_MAX)
               ? arun_q : arun_q + 8'h01;
    end
    if (e3)
      analog_signal_loss_d = (arun_d >= lrd_pkg::LOS_RUN_C);
    else
      analog_signal_loss_d = amp_low_i;
    if (e3 || ctrl_q.digital_signal_loss_dis)
      digital_signal_loss_d = 1'b0;
    if (ctrl_q.analog_signal_loss_dis)
      analog_signal_loss_d = 1'b0;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {last_pol_q, have_p_q, vpol_q, have_v_q} <= 4'h0;
      {sr_q, zrun_q, arun_q} <= 20'h0_0000;
      {win_q, ones_q} <= 16'h0000;
      {digital_signal_loss_q, analog_signal_loss_q, pos_q, neg_q, lcv_q} <= 5'h00;
    end
    else
    begin
      {last_pol_q, have_p_q} <= {last_pol_d, have_p_d};
      {vpol_q, have_v_q} <= {vpol_d, have_v_d};
      {sr_q, zrun_q, arun_q} <= {sr_d, zrun_d, arun_d};
      {win_q, ones_q} <= {win_d, ones_d};
      {digital_signal_loss_q, analog_signal_loss_q} <= {digital_signal_loss_d, analog_signal_loss_d};
      {pos_q, neg_q, lcv_q} <= {pos_d, neg_d, lcv_d};
    end
  end

  assign rx_data_pos_o = pos_q;
  assign rx_data_neg_o = neg_q;
  assign line_code_violation_o = lcv_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_LOL_TRAIN: assert property (
    (los || freq_off_i) |=> rx_loss_of_lock_o)
    else $error("loss of lock not raised");
  AST_CLK_REF: assert property (
    train_st |=> rx_clock_out_o == $past(pin_s2.rclk))
    else $error("reference clock not passed in training");
  AST_CLK_REC: assert property (
    !train_st |=> rx_clock_out_o == $past(pin_s2.lclk))
    else $error("recovered clock not passed");
  AST_LCV_ZRUN: assert property (
    bit_en && !single_rail && !pulse && zrun_q == run_len - 8'h01
    |=> line_code_violation_o)
    else $error("zero run violation missed");
  AST_BYPASS: assert property (
    bit_en && single_rail && !(mute_en && los)
    |=> rx_data_pos_o == $past(pin_s2.pos))
    else $error("single rail data not bypassed");
  AST_DIGITAL_SIGNAL_LOSS_SET: assert property (
    bit_en && !pulse && !e3 && !ctrl_q.digital_signal_loss_dis
    && zrun_q == lrd_pkg::LOS_RUN_C - 8'h01 |=> digital_signal_loss_q ##1 los)
    else $error("digital loss not declared at 175 zeros");
  AST_STAT_RD: assert property (
    rd_i && addr_i == lrd_pkg::ADDR_STAT
    |=> rdata_o[3] == $past(los) && rdata_o[0] == $past(train_st))
    else $error("status read wrong");
  AST_ANALOG_SIGNAL_LOSS_OFF: assert property (
    ctrl_q.analog_signal_loss_dis |=> !analog_signal_loss_q)
    else $error("analog loss not disabled");
  AST_MUTE: assert property (
    bit_en && mute_en && los |=> !rx_data_pos_o && !rx_data_neg_o)
    else $error("data not muted in loss");
  COV_SUB: cover property (bit_en && sub_ok && !single_rail);
  COV_DIGITAL_SIGNAL_LOSS: cover property (!digital_signal_loss_q ##1 digital_signal_loss_q);
  COV_LOCK: cover property (train_st ##1 !train_st);

endmodule : lrd_line_receiver
`default_nettype wire

// file: src/lrd_pkg.sv
// lrd_pkg: constants, register map and types of the line receiver
// assumes: used by lrd_line_receiver only, every use scoped lrd_pkg::
package lrd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;

  typedef struct packed {
    logic e3_mode;
    logic digital_signal_loss_dis;
    logic analog_signal_loss_dis;
    logic los_mute;
    logic mon_gain;
    logic eq_en;
    logic single_rail;
  } lrd_ctrl_t;

  localparam lrd_ctrl_t CTRL_RST = 7'h02;

  typedef struct packed {
    logic los;
    logic analog_signal_loss;
    logic digital_signal_loss;
    logic lol;
  } lrd_stat_t;

  // ----------------------------------------------------------------
  // pins crossing into the clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic host;
    logic rail;
    logic eq;
    logic mon;
    logic mute;
    logic lclk;
    logic rclk;
    logic pos;
    logic neg;
  } lrd_pins_t;

  localparam lrd_pins_t PINS_RST = 9'h000;

  // ----------------------------------------------------------------
  // line code and loss counts, in bit periods
  // ----------------------------------------------------------------
  localparam int LOS_RUN = 175;
  localparam int LOS_PCT = 33;
  localparam logic [7:0] LOS_RUN_C = 8'(LOS_RUN);
  localparam logic [7:0] CLR_ONES = 8'(LOS_RUN * LOS_PCT / 100 + 1);
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] B3ZS_RUN = 8'h03;
  localparam logic [7:0] HDB3_RUN = 8'h04;
  localparam logic [7:0] B3ZS_SUBZ = 8'h01;
  localparam logic [7:0] HDB3_SUBZ = 8'h02;

  typedef enum logic {
    CDR_TRAIN,
    CDR_RECOVER
  } lrd_cdr_t;

endpackage : lrd_pkg

// file: bench/lrd_line_tx_model.sv
// lrd_line_tx_model: far-end transmitter, retimed rails and line clock
// assumes: bench pushes {pos,neg} symbols into q; 400 ns bit period
`timescale 1ns/1ps
`default_nettype none
module lrd_line_tx_model (
  input wire logic marks_i, // idle fill: 1 marks, 0 spaces
  output logic line_clock_o, // line clock, runs free like a live line
  output logic pos_o, // positive pulse
  output logic neg_o // negative pulse
);
  logic [1:0] q[$];
  logic last_neg;
  // ------
  // symbol pump: data moves mid low phase, held across the rise
  // ------
  initial
  begin
    {line_clock_o, pos_o, neg_o, last_neg} = 4'h0;
    forever
    begin
      #100;
      if (q.size() > 0)
        {pos_o, neg_o} = q.pop_front();
      else
        {pos_o, neg_o} = {marks_i & last_neg, marks_i & ~last_neg};
      if (pos_o | neg_o)
        last_neg = neg_o;
      #100 line_clock_o = 1'b1;
      #200 line_clock_o = 1'b0;
    end
  end
endmodule : lrd_line_tx_model
`default_nettype wire

// file: bench/lrd_line_receiver_bench.sv
// lrd_line_receiver_bench: self-checking bench of the line receiver
// assumes: lrd_line_tx_model drives the line side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
  end
module lrd_line_receiver_bench;
  logic ref_clk, rst, refc, freq_off, amp_low, host, rail, eqp, monp, mutep;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d, n;
  logic wr, rd, rclk, dpos, dneg, lcv, lol, los, eqo, mono, cnt_en;
  logic lclk, lpos, lneg;
  int err_count, comparisons, cyc, nlcv, nzero, nones, nneg;
  // ------
  // clocks, counters, timeout
  // ------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    refc = 1'b0;
    #13;
    forever #300 refc = ~refc;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cnt_en && lcv !== 1'b0)
      nlcv++;
    if (cyc == 30000)
    begin
      err_count++;
      finish_test();
    end
  end
  always @(posedge lclk)
    if (cnt_en)
    begin
      nzero += int'(dpos === 1'b0);
      nones += int'(dpos === 1'b1);
      nneg += int'(dneg === 1'b1);
    end
  lrd_line_tx_model P (.marks_i(1'b1), .line_clock_o(lclk), .pos_o(lpos),
    .neg_o(lneg));
  lrd_line_receiver DUT (.ref_clk_i(ref_clk), .rst_i(rst),
    .reference_clock_in_i(refc), .line_clock_i(lclk),
    .line_in_pos_i(lpos), .line_in_neg_i(lneg), .freq_off_i(freq_off),
    .amp_low_i(amp_low), .host_mode_i(host), .rail_format_select_i(rail),
    .rx_equalizer_enable_i(eqp), .rx_monitor_gain_enable_i(monp),
    .loss_data_mute_i(mutep), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .rx_clock_out_o(rclk),
    .rx_data_pos_o(dpos), .rx_data_neg_o(dneg),
    .line_code_violation_o(lcv), .rx_loss_of_lock_o(lol),
    .combined_signal_loss_o(los), .rx_equalizer_enable_o(eqo),
    .rx_monitor_gain_enable_o(mono));
  // ------
  // helpers
  // ------
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    v = rdata;
  endtask : rd_reg
  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cycles
  task automatic bits(input int k);
    repeat (k) @(posedge lclk);
  endtask : bits
  // second interval only: the first may straddle a clock switch
  task automatic per(output logic [31:0] v);
    time t;
    @(posedge rclk);
    @(posedge rclk);
    t = $time;
    @(posedge rclk);
    v = 32'(($time - t) / 50);
  endtask : per
  task automatic win(input int k);
    {nlcv, nzero, nones, nneg} = '0;
    cnt_en = 1'b1;
    bits(k);
    cnt_en = 1'b0;
  endtask : win
  task automatic zeros(input int k);
    repeat (k) P.q.push_back(2'b00);
    wait (P.q.size() == 0);
    bits(3);
  endtask : zeros
  // counts only while s passes, with margin for the decoder delay
  task automatic seq(input string pre, input string s, input string post);
    string a;
    a = {pre, s, post};
    for (int i = 0; i < a.len(); i++)
      P.q.push_back(a[i] == "P" ? 2'b10 : a[i] == "N" ? 2'b01 : 2'b00);
    {nlcv, nzero, nones, nneg} = '0;
    wait (P.q.size() <= s.len() + post.len() + 4);
    cnt_en = 1'b1;
    wait (P.q.size() == 0);
    cnt_en = 1'b0;
  endtask : seq
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    rd_reg(4'h0, d);
    `CHK("ctrl reset", 32'h0000_0002, d)
    wr_reg(4'h0, 32'h0000_007F);
    rd_reg(4'h0, d);
    `CHK("ctrl rw", 32'h0000_007F, d)
    wr_reg(4'h8, 32'hFFFF_FFFF);
    rd_reg(4'h8, d);
    `CHK("unmapped", 32'h0000_0000, d)
    wr_reg(4'h0, 32'h0000_0002);
  endtask : t_regs
  task automatic t_lock();
    cycles(200);
    @(posedge ref_clk) freq_off <= 1'b1;
    cycles(4);
    `CHK("lol pin", 1'b1, lol)
    rd_reg(4'h4, d);
    `CHK("lol bit", 32'h0000_0001, d)
    per(n);
    `CHK("train clock", 32'h0000_000C, n)
    @(posedge ref_clk) freq_off <= 1'b0;
    cycles(20);
    `CHK("lol clear", 1'b0, lol)
    per(n);
    `CHK("line clock", 32'h0000_0008, n)
  endtask : t_lock
  task automatic t_dec();
    seq("PNPN00NPNPNPNPNP", "00PNPN0N", "PNPNPNPN");
    `CHK("subst lcv", 0, nlcv)
    `CHK("subst zeros", 6, nzero)
    `CHK("dual neg", 0, nneg)
    seq("PNPN00NPNPNPNPNP", "000NPN00N", "PNPNPNPN");
    `CHK("code errors", 2, nlcv)
  endtask : t_dec
  task automatic t_rail();
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(4'h0, i == 0 ? 32'h0000_0003 : 32'h0000_0002);
      @(posedge ref_clk);
      host <= (i == 0);
      rail <= (i == 1);
      cycles(6);
      seq("PPPPPPPP", "PPNN000N", "PPPPPPPP");
      `CHK("raw lcv", 0, nlcv)
      `CHK("raw zeros", 6, nzero)
      `CHK("raw neg", 3, nneg)
    end
    @(posedge ref_clk);
    host <= 1'b1;
    rail <= 1'b0;
    wr_reg(4'h0, 32'h0000_0002);
  endtask : t_rail
  task automatic t_digital_signal_loss();
    zeros(174);
    `CHK("digital_signal_loss 174", 1'b0, los)
    zeros(175);
    `CHK("digital_signal_loss 175", 1'b1, los)
    `CHK("lol in los", 1'b1, lol)
    rd_reg(4'h4, d);
    `CHK("digital_signal_loss status", 32'h0000_000B, d)
    per(n);
    `CHK("los clock", 32'h0000_000C, n)
    for (int k = 0; k < 8000 && los !== 1'b0; k++)
      @(posedge ref_clk);
    `CHK("digital_signal_loss clear", 1'b0, los)
  endtask : t_digital_signal_loss
  task automatic t_analog_signal_loss();
    wr_reg(4'h0, 32'h0000_000B);
    @(posedge ref_clk) amp_low <= 1'b1;
    cycles(6);
    `CHK("analog_signal_loss los", 1'b1, los)
    rd_reg(4'h4, d);
    `CHK("analog_signal_loss status", 32'h0000_000D, d)
    // let one slow training strobe pass so the mute has reached the pins
    bits(4);
    win(16);
    `CHK("muted", 0, nones)
    @(posedge ref_clk) amp_low <= 1'b0;
    bits(20);
    win(16);
    `CHK("unmuted", 8, nones)
    @(posedge ref_clk);
    host <= 1'b0;
    mutep <= 1'b1;
    amp_low <= 1'b1;
    bits(4);
    win(16);
    `CHK("pin muted", 0, nones)
    @(posedge ref_clk);
    host <= 1'b1;
    mutep <= 1'b0;
    amp_low <= 1'b0;
    cycles(4);
    wr_reg(4'h0, 32'h0000_001B);
    @(posedge ref_clk) amp_low <= 1'b1;
    cycles(6);
    `CHK("analog_signal_loss off", 1'b0, los)
    rd_reg(4'h4, d);
    `CHK("analog_signal_loss off bit", 32'h0000_0000, d)
    @(posedge ref_clk) amp_low <= 1'b0;
    wr_reg(4'h0, 32'h0000_0002);
  endtask : t_analog_signal_loss
  task automatic t_eq();
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(4'h0, k[1] ? 32'h0000_0006 : 32'h0000_0000);
      @(posedge ref_clk);
      host <= k[2];
      eqp <= k[0];
      monp <= k[0];
      cycles(6);
      `CHK("eq", k[2] ? k[1] : k[0], eqo)
      `CHK("mon", k[1] | k[0], mono)
    end
    @(posedge ref_clk);
    host <= 1'b1;
    {eqp, monp} <= 2'b00;
  endtask : t_eq
  task automatic t_e3();
    wr_reg(4'h0, 32'h0000_0040);
    bits(20);
    seq("PN000NPNPNPNPNPN", "P00PN000N", "PNPNPNPN");
    `CHK("hdb3 lcv", 0, nlcv)
    `CHK("hdb3 zeros", 8, nzero)
    @(posedge ref_clk) amp_low <= 1'b1;
    bits(160);
    `CHK("e3 early", 1'b0, los)
    bits(30);
    `CHK("e3 los", 1'b1, los)
  endtask : t_e3
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    {rst, freq_off, amp_low, host, rail, eqp, monp, mutep} = 8'h80;
    {addr, wdata, wr, rd, cnt_en} = '0;
    {err_count, comparisons, cyc} = '0;
    cycles(5);
    `CHK("lol at reset", 1'b1, lol)
    cycles(5);
    rst <= 1'b0;
    host <= 1'b1;
    t_regs();
    t_lock();
    t_dec();
    t_rail();
    t_digital_signal_loss();
    t_analog_signal_loss();
    t_eq();
    t_e3();
    finish_test();
  end
endmodule : lrd_line_receiver_bench
`default_nettype wire
